/* File: asc_pkg.sv */
// shared constants, register map and types for the converter sequencing block
package asc_pkg;
    localparam int          ADDR_W       = 12;
    localparam int          RES_W        = 10;
    localparam int          CH_W         = 3;
    localparam int          PRS_W        = 5;
    localparam int          DIV_W        = 7;
    // register indices; the byte address is four times the index
    localparam logic [7:0]  IDX_CLK_DIV  = 8'hf2;
    localparam logic [7:0]  IDX_CONTROL  = 8'hf3;
    localparam logic [7:0]  IDX_RES_LOW  = 8'hf4;
    localparam logic [7:0]  IDX_RES_HIGH = 8'hf5;
    localparam logic [7:0]  IDX_PIN_CFG  = 8'hf6;
    // control register fields
    localparam int          CTL_HOLD     = 6;
    localparam int          CTL_EN       = 5;
    localparam int          CTL_DONE     = 4;
    localparam int          CTL_START    = 3;
    localparam int          CTL_CH_LSB   = 0;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [7:0]  CTL_WMASK    = 8'h6f;
    localparam logic [7:0]  CLK_WMASK    = 8'h1f;
    localparam logic [31:0] RD_ZERO      = 32'h0000_0000;
    // result split between the two bytes
    localparam int          RES_HI_LSB   = 2;
    localparam int          RES_LO_W     = 2;
    // prescaler
    localparam logic [DIV_W-1:0] PRS_ZERO_DIV = 7'h40;
    localparam int          X1_SHIFT     = 2;
    localparam int          X2_SHIFT     = 1;
    // one sample-and-hold period plus ten bit periods
    localparam logic [3:0]  CONV_TICKS   = 4'hb;
    localparam logic [3:0]  TICK_ZERO    = 4'h0;
    localparam logic [3:0]  TICK_ONE     = 4'h1;

    typedef enum logic [0:0] {
        ASC_IDLE    = 1'b0,
        ASC_CONVERT = 1'b1
    } asc_state_t;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        reg_hit = (addr == {2'b00, idx, 2'b00});
    endfunction : reg_hit
endpackage : asc_pkg

/* File: asc_tick_if.sv */
// converter clock request and tick between sequencer and prescaler
`timescale 1ns/1ps
`default_nettype none
interface asc_tick_if;
    import asc_pkg::*;
    logic             run;
    logic [PRS_W-1:0] divide;
    logic             double_speed;
    logic             tick;
    modport ctl (output run, output divide, output double_speed, input tick);
    modport gen (input run, input divide, input double_speed, output tick);
endinterface : asc_tick_if
`default_nettype wire

/* File: asc_prescaler.sv */
// converter clock prescaler: one tick per converter clock period
`timescale 1ns/1ps
`default_nettype none
module asc_prescaler
    import asc_pkg::*;
#(
    parameter int CNT_W = DIV_W
) (
    input  wire logic clock,
    input  wire logic rst,
    asc_tick_if.gen   tk
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] gap;
    logic             seen;

    always_comb begin
        if (tk.divide == '0) begin
            period = PRS_ZERO_DIV;
        end else if (tk.double_speed) begin
            period = CNT_W'({2'b00, tk.divide} << X2_SHIFT);
        end else begin
            period = CNT_W'({2'b00, tk.divide} << X1_SHIFT);
        end
    end

    // counter restarts with run so the first period after a start is whole
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt     <= '0;
            tk.tick <= 1'b0;
        end else if (!tk.run) begin
            cnt     <= '0;
            tk.tick <= 1'b0;
        end else if (cnt == period - CNT_W'(1)) begin
            cnt     <= '0;
            tk.tick <= 1'b1;
        end else begin
            cnt     <= cnt + CNT_W'(1);
            tk.tick <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gap  <= '0;
            seen <= 1'b0;
        end else if (!tk.run) begin
            gap  <= '0;
            seen <= 1'b0;
        end else if (tk.tick) begin
            gap  <= '0;
            seen <= 1'b1;
        end else begin
            gap  <= gap + CNT_W'(1);
        end
    end

    a_tick_spacing: assert property (@(posedge clock) disable iff (rst)
        tk.tick && seen && $stable(period) && $past(tk.run) |-> gap == period - CNT_W'(1))
        else $error("converter tick spacing differs from prescaler period");
endmodule : asc_prescaler
`default_nettype wire

/* File: asc_top.sv */
// converter sequencing control: apb registers, conversion sequencer, result bytes
`timescale 1ns/1ps
`default_nettype none
module asc_top
    import asc_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              double_speed_clocking,
    input  wire logic [RES_W-1:0]  core_result,
    output logic [7:0]             pin_analog_select,
    output logic                   converter_standby,
    output logic                   quiet_convert_hold,
    output logic [CH_W-1:0]        input_channel_select,
    output logic                   sample_phase,
    output logic                   convert_step,
    output logic                   conversion_done_flag
);
    asc_tick_if tk ();

    asc_state_t     state;
    asc_state_t     next_state;
    logic [7:0]     clk_div;
    logic [7:0]     pin_cfg;
    logic           hold_mode;
    logic           enable;
    logic           done_flag;
    logic           start_bit;
    logic [CH_W-1:0] chan_field;
    logic [CH_W-1:0] chan_latched;
    logic [7:0]     res_high;
    logic [7:0]     res_low;
    logic [3:0]     tick_cnt;
    logic           wr_access;
    logic           rd_mapped;
    logic           ctl_write;
    logic           start_accept;
    logic           conv_end;
    logic [7:0]     ctl_read;

    asc_prescaler #(
        .CNT_W (DIV_W)
    ) u_prescaler (
        .clock (clock),
        .rst   (rst),
        .tk    (tk.gen)
    );

    // apb slave: zero wait states, error only on unmapped addresses
    assign pready    = 1'b1;
    assign wr_access = psel && penable && pwrite;
    assign rd_mapped = reg_hit(paddr, IDX_CLK_DIV) || reg_hit(paddr, IDX_CONTROL)
                    || reg_hit(paddr, IDX_RES_LOW) || reg_hit(paddr, IDX_RES_HIGH)
                    || reg_hit(paddr, IDX_PIN_CFG);
    assign pslverr   = psel && penable && !rd_mapped;
    assign ctl_write = wr_access && reg_hit(paddr, IDX_CONTROL);

    assign ctl_read = {1'b0, hold_mode, enable, done_flag, start_bit, chan_field};

    always_comb begin
        prdata = RD_ZERO;
        if (psel && !pwrite) begin
            if (reg_hit(paddr, IDX_CLK_DIV)) begin
                prdata = {24'h00_0000, clk_div};
            end else if (reg_hit(paddr, IDX_CONTROL)) begin
                prdata = {24'h00_0000, ctl_read};
            end else if (reg_hit(paddr, IDX_RES_LOW)) begin
                prdata = {24'h00_0000, res_low};
            end else if (reg_hit(paddr, IDX_RES_HIGH)) begin
                prdata = {24'h00_0000, res_high};
            end else if (reg_hit(paddr, IDX_PIN_CFG)) begin
                prdata = {24'h00_0000, pin_cfg};
            end
        end
    end

    // start taken only when idle, enabled and the chosen pin is analog
    assign start_accept = ctl_write && pwdata[CTL_START] && (state == ASC_IDLE)
                       && pwdata[CTL_EN]
                       && pin_cfg[pwdata[CTL_CH_LSB +: CH_W]];
    assign conv_end     = (state == ASC_CONVERT) && tk.tick
                       && (tick_cnt == CONV_TICKS - TICK_ONE);

    // plain configuration registers; reserved bits are never stored
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clk_div <= RST_BYTE;
            pin_cfg <= RST_BYTE;
        end else if (wr_access) begin
            if (reg_hit(paddr, IDX_CLK_DIV)) begin
                clk_div <= pwdata[7:0] & CLK_WMASK;
            end
            if (reg_hit(paddr, IDX_PIN_CFG)) begin
                pin_cfg <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hold_mode  <= 1'b0;
            enable     <= 1'b0;
            chan_field <= '0;
        end else if (ctl_write) begin
            hold_mode  <= pwdata[CTL_HOLD];
            enable     <= pwdata[CTL_EN];
            chan_field <= pwdata[CTL_CH_LSB +: CH_W];
        end
    end

    // done flag: software may only clear it, and a new result wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            done_flag <= 1'b0;
        end else if (conv_end) begin
            done_flag <= 1'b1;
        end else if (ctl_write && !pwdata[CTL_DONE]) begin
            done_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            start_bit <= 1'b0;
        end else if (start_accept) begin
            start_bit <= 1'b1;
        end else if (conv_end || (state == ASC_CONVERT && !enable)) begin
            start_bit <= 1'b0;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ASC_IDLE: begin
                if (start_accept) begin
                    next_state = ASC_CONVERT;
                end
            end
            ASC_CONVERT: begin
                // leaving enable low aborts, the result bytes keep old data
                if (conv_end || !enable) begin
                    next_state = ASC_IDLE;
                end
            end
            default: begin
                next_state = ASC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= ASC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_cnt     <= TICK_ZERO;
            chan_latched <= '0;
        end else if (start_accept) begin
            tick_cnt     <= TICK_ZERO;
            chan_latched <= pwdata[CTL_CH_LSB +: CH_W];
        end else if (state == ASC_CONVERT && tk.tick) begin
            tick_cnt     <= tick_cnt + TICK_ONE;
        end
    end

    // both bytes load together with the flag so no read sees a mix
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            res_high <= RST_BYTE;
            res_low  <= RST_BYTE;
        end else if (conv_end) begin
            res_high <= core_result[RES_W-1:RES_HI_LSB];
            res_low  <= {6'h00, core_result[RES_LO_W-1:0]};
        end
    end

    assign tk.run          = (state == ASC_CONVERT);
    assign tk.divide       = clk_div[PRS_W-1:0];
    assign tk.double_speed = double_speed_clocking;

    assign pin_analog_select    = pin_cfg;
    assign converter_standby    = !enable;
    assign quiet_convert_hold   = (state == ASC_CONVERT) && hold_mode;
    assign input_channel_select = chan_latched;
    assign sample_phase         = (state == ASC_CONVERT) && (tick_cnt == TICK_ZERO);
    assign convert_step         = tk.tick;
    assign conversion_done_flag = done_flag;

    sequence s_accept;
        start_accept;
    endsequence

    sequence s_finish;
        conv_end;
    endsequence

    // enable dropped mid-conversion, not on the finishing tick
    sequence s_abort;
        state == ASC_CONVERT && !enable && !conv_end;
    endsequence

    a_pin_config: assert property (@(posedge clock) disable iff (rst)
        wr_access && reg_hit(paddr, IDX_PIN_CFG) |=> pin_analog_select == $past(pwdata[7:0]))
        else $error("pin configuration not mirrored to analog selects");

    a_hold_during: assert property (@(posedge clock) disable iff (rst)
        s_accept |=> quiet_convert_hold == $past(pwdata[CTL_HOLD]))
        else $error("processor hold does not follow hold bit during conversion");

    // a write that enables and starts at once is a legal start
    a_standby_stop: assert property (@(posedge clock) disable iff (rst)
        !enable && !start_accept |=> state == ASC_IDLE && !start_bit)
        else $error("conversion running while converter in standby");

    a_finish_effects: assert property (@(posedge clock) disable iff (rst)
        s_finish |=> done_flag && !start_bit && state == ASC_IDLE)
        else $error("conversion end did not set flag and clear start");

    a_start_busy: assert property (@(posedge clock) disable iff (rst)
        s_accept |=> start_bit && state == ASC_CONVERT
            ##0 (start_bit && state == ASC_CONVERT)[*2])
        else $error("start bit not held while converting");

    a_channel_latch: assert property (@(posedge clock) disable iff (rst)
        s_accept |=> input_channel_select == $past(pwdata[CTL_CH_LSB +: CH_W]))
        else $error("converted channel differs from channel written");

    a_result_bytes: assert property (@(posedge clock) disable iff (rst)
        s_finish |=> res_high == $past(core_result[RES_W-1:RES_HI_LSB])
            && res_low[RES_LO_W-1:0] == $past(core_result[RES_LO_W-1:0]) && done_flag)
        else $error("result bytes not loaded with flag");

    a_conv_length: assert property (@(posedge clock) disable iff (rst)
        s_finish |-> tick_cnt == 4'ha && $past(state == ASC_CONVERT))
        else $error("conversion did not span eleven converter periods");

    a_no_analog: assert property (@(posedge clock) disable iff (rst)
        ctl_write && state == ASC_IDLE && !pin_cfg[pwdata[CTL_CH_LSB +: CH_W]]
            |=> state == ASC_IDLE && !start_bit)
        else $error("conversion started on a non-analog pin");

    a_restart_ignored: assert property (@(posedge clock) disable iff (rst)
        state == ASC_CONVERT && enable && ctl_write && pwdata[CTL_START] && !conv_end
            |=> tick_cnt != TICK_ZERO || $past(tick_cnt) == TICK_ZERO)
        else $error("start during conversion restarted the sequence");

    a_flag_sticky: assert property (@(posedge clock) disable iff (rst)
        done_flag && !ctl_write |=> done_flag)
        else $error("done flag cleared without software write");

    a_abort_keep: assert property (@(posedge clock) disable iff (rst)
        s_abort |=> state == ASC_IDLE && $stable(res_high) && $stable(res_low))
        else $error("aborted conversion changed the result bytes");

    a_done_clear: assert property (@(posedge clock) disable iff (rst)
        ctl_write && !pwdata[CTL_DONE] && !conv_end |=> !done_flag)
        else $error("software clear of the done flag had no effect");

    a_result_readonly: assert property (@(posedge clock) disable iff (rst)
        wr_access && (reg_hit(paddr, IDX_RES_HIGH) || reg_hit(paddr, IDX_RES_LOW)) && !conv_end
            |=> $stable(res_high) && $stable(res_low))
        else $error("write to a result byte changed it");

    a_idle_quiet: assert property (@(posedge clock) disable iff (rst)
        state == ASC_IDLE && $past(state) == ASC_IDLE |-> !convert_step)
        else $error("converter period pulse while idle");

    a_start_held: assert property (@(posedge clock) disable iff (rst)
        state == ASC_CONVERT |-> start_bit)
        else $error("start bit low while a conversion runs");
endmodule : asc_top
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the converter sequencing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module tb
    import asc_pkg::*;
;
    logic              clock                 = 1'b0;
    logic              rst                   = 1'b1;
    logic              psel                  = 1'b0;
    logic              penable               = 1'b0;
    logic              pwrite                = 1'b0;
    logic [ADDR_W-1:0] paddr                 = '0;
    logic [31:0]       pwdata                = '0;
    logic              double_speed_clocking = 1'b0;
    logic [RES_W-1:0]  core_result           = '0;
    logic              pready;
    logic [31:0]       prdata;
    logic              pslverr;
    logic [7:0]        pin_analog_select;
    logic              converter_standby;
    logic              quiet_convert_hold;
    logic [CH_W-1:0]   input_channel_select;
    logic              sample_phase;
    logic              convert_step;
    logic              conversion_done_flag;
    int                n_mismatch            = 0;
    int                check_count           = 0;
    int                cyc                   = 0;
    int                pulses                = 0;

    asc_top uut (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .double_speed_clocking(double_speed_clocking),
        .core_result(core_result), .pin_analog_select(pin_analog_select),
        .converter_standby(converter_standby), .quiet_convert_hold(quiet_convert_hold),
        .input_channel_select(input_channel_select), .sample_phase(sample_phase),
        .convert_step(convert_step), .conversion_done_flag(conversion_done_flag)
    );

    always #20 clock = ~clock;

    // free cycle count and converter period pulses, read before the edge updates land
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (convert_step === 1'b1) begin
            pulses <= pulses + 1;
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    // one apb transfer; read data and error taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
        int k;
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            n_mismatch++;
            final_report();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        logic       e;
        apb(1'b1, idx, d, r, e);
    endtask : wr

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] r;
        logic       e;
        apb(1'b0, idx, 8'h00, r, e);
        `CHK(r, exp)
    endtask : rdchk

    function automatic logic [9:0] res_of(input logic [2:0] ch);
        res_of = 10'h155 + {7'h0, ch} * 10'h49;
    endfunction : res_of

    task automatic reset_values();
        logic [7:0] r;
        logic       e;
        `CHK(converter_standby, 1'b1)
        rdchk(IDX_CLK_DIV, 8'h00);
        rdchk(IDX_CONTROL, 8'h00);
        rdchk(IDX_RES_LOW, 8'h00);
        rdchk(IDX_RES_HIGH, 8'h00);
        rdchk(IDX_PIN_CFG, 8'h00);
        apb(1'b0, 8'h10, 8'h00, r, e);
        `CHK({e, r}, 9'h100)
        wr(IDX_RES_HIGH, 8'hff);
        rdchk(IDX_RES_HIGH, 8'h00);
        wr(IDX_CLK_DIV, 8'h1f);
        rdchk(IDX_CLK_DIV, 8'h1f);
    endtask : reset_values

    // start on a channel whose pin is not analog must do nothing
    task automatic unconfigured();
        int p0;
        wr(IDX_PIN_CFG, 8'h04);
        rdchk(IDX_PIN_CFG, 8'h04);
        `CHK(pin_analog_select, 8'h04)
        p0 = pulses;
        wr(IDX_CONTROL, 8'h29);
        rdchk(IDX_CONTROL, 8'h21);
        repeat (60) @(posedge clock);
        `CHK(pulses - p0, 0)
        `CHK(conversion_done_flag, 1'b0)
    endtask : unconfigured

    task automatic conv(input logic [4:0] div, input logic ds, input logic [2:0] ch,
                        input logic hold, input logic again);
        int         p;
        int         t0;
        int         p0;
        int         k;
        logic [9:0] res;
        logic [7:0] c;
        p = (div == 0) ? 64 : (ds ? 2 * div : 4 * div);
        res = res_of(ch);
        c = {1'b0, hold, 1'b1, 1'b0, 1'b1, ch};
        core_result <= res;
        double_speed_clocking <= ds;
        wr(IDX_CLK_DIV, {3'h0, div});
        wr(IDX_CONTROL, c);
        t0 = cyc;
        p0 = pulses;
        @(posedge clock);
        `CHK(sample_phase, 1'b1)
        `CHK(quiet_convert_hold, hold)
        `CHK(input_channel_select, ch)
        `CHK(converter_standby, 1'b0)
        rdchk(IDX_CONTROL, c);
        if (again) begin
            wr(IDX_CONTROL, c);
        end
        k = 0;
        while (conversion_done_flag !== 1'b1 && k < 2000) begin
            @(posedge clock);
            k++;
        end
        if (k >= 2000) begin
            n_mismatch++;
            final_report();
        end
        // tick and flag are both registered; the flag is seen one edge after it sets
        `CHK(cyc - t0, 11 * p + 2)
        `CHK(pulses - p0, 11)
        `CHK(quiet_convert_hold, 1'b0)
        `CHK(sample_phase, 1'b0)
        rdchk(IDX_CONTROL, c ^ 8'h18);
        rdchk(IDX_RES_HIGH, res[9:2]);
        rdchk(IDX_RES_LOW, {6'h0, res[1:0]});
        rdchk(IDX_CONTROL, c ^ 8'h18);
        wr(IDX_CONTROL, c ^ 8'h08);
        rdchk(IDX_CONTROL, c ^ 8'h08);
    endtask : conv

    // clearing enable mid-conversion aborts; start without enable is refused
    task automatic abort_run();
        logic [9:0] kept;
        kept = res_of(3'h6);
        wr(IDX_CLK_DIV, 8'h01);
        core_result <= 10'h3ff;
        wr(IDX_CONTROL, 8'h2b);
        wr(IDX_CONTROL, 8'h03);
        @(posedge clock);
        `CHK(converter_standby, 1'b1)
        repeat (60) @(posedge clock);
        `CHK(conversion_done_flag, 1'b0)
        rdchk(IDX_CONTROL, 8'h03);
        rdchk(IDX_RES_HIGH, kept[9:2]);
        wr(IDX_CONTROL, 8'h0b);
        rdchk(IDX_CONTROL, 8'h03);
    endtask : abort_run

    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        reset_values();
        unconfigured();
        wr(IDX_PIN_CFG, 8'hff);
        // every channel code, mixed clocking and hold; channel 2 gets a second start
        for (int ch = 0; ch < 8; ch++) begin
            conv(5'h01, ch[0], ch[2:0], ch[1], ch == 2);
        end
        conv(5'h03, 1'b1, 3'h5, 1'b0, 1'b0);
        conv(5'h00, 1'b0, 3'h6, 1'b1, 1'b0);
        abort_run();
        final_report();
    end
endmodule : tb
`default_nettype wire
